// File: verilog/pm_pkg.sv
// Shared constants of the power mode and wake-up manager and its CPU end.
// Assumes both ends run on one clock, CLK_SYS at 25 MHz.
package pm_pkg;

   // --------------------------------------------------------------
   // Link register indices
   // --------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int SEL_W = 4;
   localparam int NUM_IDX = 16;
   localparam logic [SEL_W-1:0] REG_PWR_CTL = 4'h0;
   localparam logic [SEL_W-1:0] REG_CLK_SEL = 4'h1;
   localparam logic [SEL_W-1:0] REG_BOD_CTL = 4'h2;
   localparam logic [SEL_W-1:0] REG_CLK_DSTS = 4'h3;
   localparam logic [SEL_W-1:0] REG_TMR_STS = 4'h4;
   localparam logic [SEL_W-1:0] REG_WDT_CTL = 4'h5;
   localparam logic [SEL_W-1:0] REG_UART_WK = 4'h6;
   localparam logic [SEL_W-1:0] REG_LIN_WK = 4'h7;
   localparam logic [SEL_W-1:0] REG_I2C_WK = 4'h8;
   localparam logic [SEL_W-1:0] REG_UNIVERSAL_SERIAL_UNIT_PROT = 4'h9;
   localparam logic [SEL_W-1:0] REG_UNIVERSAL_SERIAL_UNIT_WK = 4'ha;
   localparam logic [SEL_W-1:0] REG_ANALOG_COMPARATOR_STS = 4'hb;
   localparam logic [SEL_W-1:0] REG_SPI_WK = 4'hc;
   localparam logic [SEL_W-1:0] REG_PORT_SRC = 4'hd;
   localparam logic [SEL_W-1:0] REG_MODE = 4'he;
   localparam int FLAG_FIRST = 2;
   localparam int FLAG_LAST = 13;
   localparam int NUM_FLAG_REGS = FLAG_LAST - FLAG_FIRST + 1;

   // --------------------------------------------------------------
   // Field layouts and reset values
   // --------------------------------------------------------------
   localparam int PWR_LXT_BIT = 1;
   localparam int PWR_LOW_SPEED_RC_OSC_BIT = 2;
   localparam int PWR_POWERDOWN_ENABLE_BIT = 7;
   localparam logic [DATA_W-1:0] PWR_CTL_MASK = 32'h0000_0086;
   localparam logic [DATA_W-1:0] PWR_CTL_RST = 32'h0000_0000;
   localparam int SEL_TMR_LSB = 0;
   localparam int SEL_WDT_LSB = 2;
   localparam int SEL_UART_LSB = 4;
   localparam logic [DATA_W-1:0] CLK_SEL_MASK = 32'h0000_003f;
   localparam logic [DATA_W-1:0] CLK_SEL_RST = 32'h0000_0000;
   localparam logic [1:0] SRC_FAST = 2'h0;
   localparam logic [1:0] SRC_LXT = 2'h1;
   localparam logic [1:0] SRC_LOW_SPEED_RC_OSC = 2'h2;
   localparam logic [DATA_W-1:0] MASK_BOD = 32'h0000_0010;
   localparam logic [DATA_W-1:0] MASK_CLOCK_FAIL_EVENT = 32'h0000_0002;
   localparam logic [DATA_W-1:0] MASK_TMR = 32'h0000_0003;
   localparam logic [DATA_W-1:0] MASK_WDT = 32'h0000_0020;
   localparam logic [DATA_W-1:0] MASK_UART = 32'h0000_001f;
   localparam logic [DATA_W-1:0] MASK_LIN = 32'h2000_0000;
   localparam logic [DATA_W-1:0] MASK_I2C = 32'h0000_0003;
   localparam logic [DATA_W-1:0] MASK_I2C_WAKE_INTERRUPT_FLAG = 32'h0000_0001;
   localparam logic [DATA_W-1:0] MASK_UNIVERSAL_SERIAL_UNIT_PROT = 32'h0001_0000;
   localparam logic [DATA_W-1:0] MASK_UNIVERSAL_SERIAL_UNIT_WK = 32'h0000_0001;
   localparam logic [DATA_W-1:0] MASK_ANALOG_COMPARATOR = 32'h0000_0300;
   localparam logic [DATA_W-1:0] MASK_SPI = 32'h0000_0001;
   localparam logic [DATA_W-1:0] MASK_PORT = 32'h0000_ffff;
   localparam int I2C_ACKDONE_BIT = 1;
   localparam int UNIVERSAL_SERIAL_UNIT_ACKDONE_BIT = 16;

   // --------------------------------------------------------------
   // Clock gate vector positions
   // --------------------------------------------------------------
   localparam int GATE_HXT = 0;
   localparam int GATE_FAST_RC = 1;
   localparam int GATE_PLL = 2;
   localparam int GATE_BUS = 3;
   localparam int GATE_FLASH = 4;
   localparam int GATE_GPIO = 5;
   localparam int GATE_DMA = 6;
   localparam int GATE_PWM = 7;
   localparam int GATE_UNIVERSAL_SERIAL_UNIT = 8;
   localparam int GATE_ADC = 9;
   localparam int GATE_ANALOG_COMPARATOR = 10;
   localparam int GATE_WINDOW_WATCHDOG = 11;
   localparam int NUM_GATES = 12;

   // --------------------------------------------------------------
   // CPU end APB map
   // --------------------------------------------------------------
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] APB_CMD = 8'h00;
   localparam logic [APB_AW-1:0] APB_ADDR = 8'h04;
   localparam logic [APB_AW-1:0] APB_WDATA = 8'h08;
   localparam logic [APB_AW-1:0] APB_RDATA = 8'h0c;
   localparam logic [APB_AW-1:0] APB_STATUS = 8'h10;
   localparam int CMD_WFI_BIT = 0;
   localparam int CMD_DSS_BIT = 1;
   localparam int STS_BUSY_BIT = 2;

   typedef enum logic [1:0] {
      MODE_NORMAL = 2'b00,
      MODE_IDLE = 2'b01,
      MODE_PDOWN = 2'b10,
      MODE_WAKE = 2'b11
   } pm_mode_t;

endpackage

// File: verilog/pm_link_if.sv
// Link between the CPU end and the power manager end.
// Assumes both ends share the clock and reset given to the interface.
interface pm_link_if (
   input wire logic clk,
   input wire logic rst_n
);
   import pm_pkg::*;

   logic wfi;
   logic deep_sleep_select;
   logic irq_pending;
   logic reg_wr;
   logic reg_rd;
   logic [SEL_W-1:0] reg_sel;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata;
   logic reg_ack;
   pm_mode_t pm_mode;

   modport dev (
      input wfi, deep_sleep_select, irq_pending, reg_wr, reg_rd,
      input reg_sel, reg_wdata,
      output reg_rdata, reg_ack, pm_mode
   );

   modport cpu (
      output wfi, deep_sleep_select, irq_pending, reg_wr, reg_rd,
      output reg_sel, reg_wdata,
      input reg_rdata, reg_ack, pm_mode
   );
endinterface

// File: verilog/pm_cpu_end.sv
// CPU end: APB command registers that drive the link to the power
// manager. Assumes APB on CLK_SYS; IRQ_PEND comes from same-clock logic.
module pm_cpu_end
   import pm_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   pm_link_if.cpu LINK,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [APB_AW-1:0] PADDR,
   input wire logic [DATA_W-1:0] PWDATA,
   output logic [DATA_W-1:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic IRQ_PEND
);

   // --------------------------------------------------------------
   // APB decode
   // --------------------------------------------------------------
   logic wfi_ff, dss_ff, irq_ff, wr_ff, rd_ff, busy_ff;
   logic [SEL_W-1:0] sel_ff;
   logic [DATA_W-1:0] wdata_ff, rdata_ff;
   wire logic setup = PSEL & ~PENABLE;
   wire logic commit = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
   wire logic hit_cmd = PADDR == APB_CMD;
   wire logic hit_addr = PADDR == APB_ADDR;
   wire logic hit_wdata = PADDR == APB_WDATA;
   wire logic hit_rdata = PADDR == APB_RDATA;
   wire logic hit_sts = PADDR == APB_STATUS;
   wire logic mapped = hit_cmd | hit_addr | hit_wdata | hit_rdata | hit_sts;
   wire logic [DATA_W-1:0] rd_val =
      hit_cmd ? {30'h0, dss_ff, 1'b0} :
      hit_addr ? {28'h0, sel_ff} :
      hit_wdata ? wdata_ff :
      hit_rdata ? rdata_ff :
      hit_sts ? {29'h0, busy_ff, LINK.pm_mode} : '0;

   // Zero wait states: answer prepared at the setup edge
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= '0;
      end else begin
         PREADY <= setup;
         PSLVERR <= setup & ~mapped;
         PRDATA <= setup ? rd_val : '0;
      end
   end

   // --------------------------------------------------------------
   // Link drive
   // --------------------------------------------------------------
   // A register access while busy is still sent; the manager is one-cycle
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         wfi_ff <= 1'b0;
         dss_ff <= 1'b0;
         irq_ff <= 1'b0;
         wr_ff <= 1'b0;
         rd_ff <= 1'b0;
         busy_ff <= 1'b0;
         sel_ff <= '0;
         wdata_ff <= '0;
         rdata_ff <= '0;
      end else begin
         irq_ff <= IRQ_PEND;
         wfi_ff <= commit & hit_cmd & PWDATA[CMD_WFI_BIT];
         wr_ff <= commit & hit_wdata;
         rd_ff <= commit & hit_rdata;
         if (commit & hit_cmd) begin
            dss_ff <= PWDATA[CMD_DSS_BIT];
         end
         if (commit & hit_addr) begin
            sel_ff <= PWDATA[SEL_W-1:0];
         end
         if (commit & hit_wdata) begin
            wdata_ff <= PWDATA;
         end
         if (LINK.reg_ack) begin
            rdata_ff <= LINK.reg_rdata;
         end
         if (commit & (hit_wdata | hit_rdata)) begin
            busy_ff <= 1'b1;
         end else if (LINK.reg_ack) begin
            busy_ff <= 1'b0;
         end
      end
   end

   assign LINK.wfi = wfi_ff;
   assign LINK.deep_sleep_select = dss_ff;
   assign LINK.irq_pending = irq_ff;
   assign LINK.reg_wr = wr_ff;
   assign LINK.reg_rd = rd_ff;
   assign LINK.reg_sel = sel_ff;
   assign LINK.reg_wdata = wdata_ff;

endmodule

// File: verilog/pm_device_end.sv
// Power mode and wake-up manager: mode machine, clock and regulator
// gating, wake flags. Assumes wake events come from same-clock logic.
//
// Overview of operation
// - Reset lands in normal mode, all gated clocks on, slow oscillators off
// - Idle wait gates the CPU clock and the window watchdog clock
// - Power-down needs deep-sleep, powerdown enable, then wait
// - Power-down halts fast clocks, main regulator off
// - Wake from idle or power-down returns normal
// - Only listed wake sources end power-down
// - Timer, watchdog clocks follow enabled slow source
// - UART clock needs low-speed crystal source, enabled
// - Slow oscillators keep their software setting
// - Software clears wake flag before next power-down
// - Brown-out wake flag bit 4, write-one-clear
// - Clock-fail wake flag bit 1, write-one-clear
// - Timer wake and interrupt flags bits 1, 0
// - Watchdog wake flag bit 5, write-one-clear
// - UART wake flags bits 0 to 4
// - LIN wake flag bit 29, write-one-clear
// - I2C acknowledge-done cleared before its wake flag
// - Serial unit acknowledge-done bit 16 cleared first
// - Comparator wake flags bits 8 and 9
// - Serial unit SPI select wake flag bit 0
// - Port interrupt source bits cleared by writing one
module pm_device_end
   import pm_pkg::*;
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   pm_link_if.dev LINK,
   input wire logic [NUM_FLAG_REGS*DATA_W-1:0] WAKE_EVT,
   output logic CPU_CLK_EN,
   output logic [NUM_GATES-1:0] GATE_EN,
   output logic MAIN_REG_EN,
   output logic STBY_REG_EN,
   output logic LXT_EN,
   output logic LOW_SPEED_RC_OSC_EN,
   output logic TMR_CLK_EN,
   output logic WDT_CLK_EN,
   output logic UART_CLK_EN,
   output logic WAKE_REQ
);

   // --------------------------------------------------------------
   // Flag layouts
   // --------------------------------------------------------------
   function automatic logic [DATA_W-1:0] flag_mask(
      input logic [SEL_W-1:0] idx
   );
      case (idx)
         REG_BOD_CTL: flag_mask = MASK_BOD;
         REG_CLK_DSTS: flag_mask = MASK_CLOCK_FAIL_EVENT;
         REG_TMR_STS: flag_mask = MASK_TMR;
         REG_WDT_CTL: flag_mask = MASK_WDT;
         REG_UART_WK: flag_mask = MASK_UART;
         REG_LIN_WK: flag_mask = MASK_LIN;
         REG_I2C_WK: flag_mask = MASK_I2C;
         REG_UNIVERSAL_SERIAL_UNIT_PROT: flag_mask = MASK_UNIVERSAL_SERIAL_UNIT_PROT;
         REG_UNIVERSAL_SERIAL_UNIT_WK: flag_mask = MASK_UNIVERSAL_SERIAL_UNIT_WK;
         REG_ANALOG_COMPARATOR_STS: flag_mask = MASK_ANALOG_COMPARATOR;
         REG_SPI_WK: flag_mask = MASK_SPI;
         REG_PORT_SRC: flag_mask = MASK_PORT;
         default: flag_mask = '0;
      endcase
   endfunction

   // Acknowledge-done bits are status only and never wake the chip
   function automatic logic [DATA_W-1:0] wake_mask(
      input logic [SEL_W-1:0] idx
   );
      case (idx)
         REG_I2C_WK: wake_mask = MASK_I2C_WAKE_INTERRUPT_FLAG;
         REG_UNIVERSAL_SERIAL_UNIT_PROT: wake_mask = '0;
         default: wake_mask = flag_mask(idx);
      endcase
   endfunction

   function automatic logic slow_src_ok(
      input logic [1:0] src,
      input logic low_speed_crystal,
      input logic low_speed_rc_osc
   );
      slow_src_ok = (src == SRC_LXT && low_speed_crystal) || (src == SRC_LOW_SPEED_RC_OSC && low_speed_rc_osc);
   endfunction

   // --------------------------------------------------------------
   // Wake flag registers
   // --------------------------------------------------------------
   logic [DATA_W-1:0] flag_q [NUM_IDX];
   logic [NUM_IDX-1:0] wake_bits;

   for (genvar g = 0; g < NUM_IDX; g++) begin : g_reg
      localparam logic [SEL_W-1:0] IDX = SEL_W'(g);
      if (g >= FLAG_FIRST && g <= FLAG_LAST) begin : g_flag
         logic [DATA_W-1:0] flag_ff;
         wire logic [DATA_W-1:0] evt =
            WAKE_EVT[(g-FLAG_FIRST)*DATA_W +: DATA_W] & flag_mask(IDX);
         // Wake flag clear refused while its acknowledge-done is set
         wire logic [DATA_W-1:0] blk =
            (IDX == REG_I2C_WK && flag_q[REG_I2C_WK][I2C_ACKDONE_BIT]) ?
               MASK_I2C_WAKE_INTERRUPT_FLAG :
            (IDX == REG_UNIVERSAL_SERIAL_UNIT_WK &&
             flag_q[REG_UNIVERSAL_SERIAL_UNIT_PROT][UNIVERSAL_SERIAL_UNIT_ACKDONE_BIT]) ?
               MASK_UNIVERSAL_SERIAL_UNIT_WK : '0;
         wire logic [DATA_W-1:0] clr =
            (LINK.reg_wr && LINK.reg_sel == IDX) ?
               (LINK.reg_wdata & flag_mask(IDX) & ~blk) : '0;
         // Set wins over a clear in the same cycle
         wire logic [DATA_W-1:0] nxt_flag = (flag_ff & ~clr) | evt;
         always_ff @(posedge CLK_SYS or negedge RST_N) begin
            if (!RST_N) begin
               flag_ff <= '0;
            end else begin
               flag_ff <= nxt_flag;
            end
         end
         assign flag_q[g] = flag_ff;
         assign wake_bits[g] = |(flag_ff & wake_mask(IDX));
      end else begin : g_none
         assign flag_q[g] = '0;
         assign wake_bits[g] = 1'b0;
      end
   end

   // A pending flag wakes at once, so power-down is left the cycle after
   // it is entered until software has cleared it
   wire logic wake_req = |wake_bits;

   // --------------------------------------------------------------
   // Control registers and register reads
   // --------------------------------------------------------------
   logic [DATA_W-1:0] pwr_ctl_ff, clk_sel_ff, rdata_ff;
   logic ack_ff;
   pm_mode_t state_ff, nxt_state;

   wire logic powerdown_enable = pwr_ctl_ff[PWR_POWERDOWN_ENABLE_BIT];
   wire logic lxt_on = pwr_ctl_ff[PWR_LXT_BIT];
   wire logic low_speed_rc_osc_on = pwr_ctl_ff[PWR_LOW_SPEED_RC_OSC_BIT];
   wire logic [1:0] tmr_src = clk_sel_ff[SEL_TMR_LSB +: 2];
   wire logic [1:0] wdt_src = clk_sel_ff[SEL_WDT_LSB +: 2];
   wire logic [1:0] uart_src = clk_sel_ff[SEL_UART_LSB +: 2];
   wire logic wr_pwr = LINK.reg_wr && LINK.reg_sel == REG_PWR_CTL;
   wire logic wr_sel = LINK.reg_wr && LINK.reg_sel == REG_CLK_SEL;
   wire logic [DATA_W-1:0] rd_val =
      (LINK.reg_sel == REG_PWR_CTL) ? pwr_ctl_ff :
      (LINK.reg_sel == REG_CLK_SEL) ? clk_sel_ff :
      (LINK.reg_sel == REG_MODE) ? {30'h0, state_ff} :
      flag_q[LINK.reg_sel];

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         pwr_ctl_ff <= PWR_CTL_RST;
         clk_sel_ff <= CLK_SEL_RST;
         rdata_ff <= '0;
         ack_ff <= 1'b0;
      end else begin
         if (wr_pwr) begin
            pwr_ctl_ff <= LINK.reg_wdata & PWR_CTL_MASK;
         end
         if (wr_sel) begin
            clk_sel_ff <= LINK.reg_wdata & CLK_SEL_MASK;
         end
         if (LINK.reg_rd) begin
            rdata_ff <= rd_val;
         end
         ack_ff <= LINK.reg_wr | LINK.reg_rd;
      end
   end

   // --------------------------------------------------------------
   // Mode machine
   // --------------------------------------------------------------
   // Mixed deep-sleep and enable settings fall back to idle, the
   // safer of the two sleep states
   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         MODE_NORMAL: begin
            if (LINK.wfi && LINK.deep_sleep_select && powerdown_enable) begin
               nxt_state = MODE_PDOWN;
            end else if (LINK.wfi) begin
               nxt_state = MODE_IDLE;
            end
         end
         MODE_IDLE: begin
            if (LINK.irq_pending || wake_req) begin
               nxt_state = MODE_NORMAL;
            end
         end
         MODE_PDOWN: begin
            if (wake_req) begin
               nxt_state = MODE_WAKE;
            end
         end
         MODE_WAKE: begin
            nxt_state = MODE_NORMAL;
         end
         default: begin
            nxt_state = MODE_NORMAL;
         end
      endcase
   end

   // --------------------------------------------------------------
   // Clock and regulator gating
   // --------------------------------------------------------------
   // Outputs track the next state so gates move with the mode register
   wire logic nxt_pd = nxt_state == MODE_PDOWN;
   wire logic nxt_idle = nxt_state == MODE_IDLE;
   wire logic nxt_lxt = wr_pwr ? LINK.reg_wdata[PWR_LXT_BIT] : lxt_on;
   wire logic nxt_low_speed_rc_osc = wr_pwr ? LINK.reg_wdata[PWR_LOW_SPEED_RC_OSC_BIT] : low_speed_rc_osc_on;
   wire logic [NUM_GATES-1:0] nxt_gate =
      nxt_pd ? '0 :
      nxt_idle ? ~(NUM_GATES'(1) << GATE_WINDOW_WATCHDOG) : '1;

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         state_ff <= MODE_NORMAL;
         CPU_CLK_EN <= 1'b1;
         GATE_EN <= '1;
         MAIN_REG_EN <= 1'b1;
         STBY_REG_EN <= 1'b1;
         LXT_EN <= 1'b0;
         LOW_SPEED_RC_OSC_EN <= 1'b0;
         TMR_CLK_EN <= 1'b1;
         WDT_CLK_EN <= 1'b1;
         UART_CLK_EN <= 1'b1;
         WAKE_REQ <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         CPU_CLK_EN <= nxt_state == MODE_NORMAL;
         GATE_EN <= nxt_gate;
         MAIN_REG_EN <= ~nxt_pd;
         STBY_REG_EN <= 1'b1;
         LXT_EN <= nxt_lxt;
         LOW_SPEED_RC_OSC_EN <= nxt_low_speed_rc_osc;
         TMR_CLK_EN <= ~nxt_pd |
            slow_src_ok(tmr_src, nxt_lxt, nxt_low_speed_rc_osc);
         WDT_CLK_EN <= ~nxt_pd |
            slow_src_ok(wdt_src, nxt_lxt, nxt_low_speed_rc_osc);
         UART_CLK_EN <= ~nxt_pd | (uart_src == SRC_LXT && nxt_lxt);
         WAKE_REQ <= wake_req;
      end
   end

   assign LINK.reg_rdata = rdata_ff;
   assign LINK.reg_ack = ack_ff;
   assign LINK.pm_mode = state_ff;

endmodule

// File: bench/pm_link_monitor.sv
// Checker of the link between the CPU end and the power manager.
// Assumes it is instantiated beside the link interface in tb.
module pm_link_monitor
   import pm_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wfi,
   input wire logic deep_sleep_select,
   input wire logic irq_pending,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [SEL_W-1:0] reg_sel,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic [DATA_W-1:0] reg_rdata,
   input wire logic reg_ack,
   input wire pm_mode_t pm_mode
);
   timeunit 1ns;
   timeprecision 1ps;

   // ---------------------------------------------
   // Shadow of powerdown_enable, seen on the link
   // ---------------------------------------------
   logic powerdown_enable_ff;
   logic nxt_powerdown_enable;
   assign nxt_powerdown_enable = (reg_wr && reg_sel == REG_PWR_CTL) ?
      reg_wdata[PWR_POWERDOWN_ENABLE_BIT] : powerdown_enable_ff;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) powerdown_enable_ff <= 1'b0;
      else powerdown_enable_ff <= nxt_powerdown_enable;
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ---------------------------------------------
   // Mode sequencing
   // ---------------------------------------------
   a_reset_normal: assert property (
      $rose(rst_n) |-> pm_mode == MODE_NORMAL) else $error("not normal");
   a_normal_holds: assert property (
      pm_mode == MODE_NORMAL && !wfi |=> pm_mode == MODE_NORMAL)
      else $error("left normal without wait");
   a_idle_entry: assert property (
      pm_mode == MODE_NORMAL && wfi && !(deep_sleep_select && powerdown_enable_ff)
      |=> pm_mode == MODE_IDLE) else $error("idle not entered");
   a_pdown_entry: assert property (
      pm_mode == MODE_NORMAL && wfi && deep_sleep_select && powerdown_enable_ff
      |=> pm_mode == MODE_PDOWN) else $error("power-down not entered");
   a_idle_exit: assert property (
      pm_mode == MODE_IDLE && irq_pending |=> pm_mode == MODE_NORMAL)
      else $error("idle not left on interrupt");
   a_pdown_exit: assert property (
      pm_mode == MODE_PDOWN |=> pm_mode inside {MODE_PDOWN, MODE_WAKE})
      else $error("power-down left wrongly");
   a_wake_normal: assert property (
      pm_mode == MODE_WAKE |=> pm_mode == MODE_NORMAL)
      else $error("wake did not return normal");

   // ---------------------------------------------
   // Flag register access
   // ---------------------------------------------
   a_ack_follows: assert property (
      reg_wr || reg_rd |=> reg_ack) else $error("no ack");
   a_ack_spurious: assert property (
      !(reg_wr || reg_rd) |=> !reg_ack) else $error("stray ack");
   a_rdata_holds: assert property (
      !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
endmodule

// File: bench/tb.sv
// Testbench of both ends joined by the link interface.
// Assumes zero-wait APB on the CPU end and one shared clock.
module tb
   import pm_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk = 1'b0, rst_n = 1'b0, irq = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [APB_AW-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, r;
   logic pready, pslverr, e;
   logic [NUM_FLAG_REGS*DATA_W-1:0] evt = '0;
   logic cpu_clk_en, main_reg_en, stby_reg_en, lxt_en, low_speed_rc_osc_en;
   logic tmr_clk_en, wdt_clk_en, uart_clk_en, wake_req;
   logic [NUM_GATES-1:0] gate_en;
   int err_count = 0, checked = 0;
   logic [DATA_W-1:0] mt [NUM_FLAG_REGS] = '{MASK_BOD, MASK_CLOCK_FAIL_EVENT,
      MASK_TMR, MASK_WDT, MASK_UART, MASK_LIN, MASK_I2C, MASK_UNIVERSAL_SERIAL_UNIT_PROT,
      MASK_UNIVERSAL_SERIAL_UNIT_WK, MASK_ANALOG_COMPARATOR, MASK_SPI, MASK_PORT};

   initial forever #20 clk = ~clk;

   pm_link_if u_pm_link_if (.clk(clk), .rst_n(rst_n));
   pm_cpu_end u_pm_cpu_end (.CLK_SYS(clk), .RST_N(rst_n),
      .LINK(u_pm_link_if), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
      .PREADY(pready), .PSLVERR(pslverr), .IRQ_PEND(irq));
   pm_device_end u_pm_device_end (.CLK_SYS(clk), .RST_N(rst_n),
      .LINK(u_pm_link_if), .WAKE_EVT(evt), .CPU_CLK_EN(cpu_clk_en),
      .GATE_EN(gate_en), .MAIN_REG_EN(main_reg_en),
      .STBY_REG_EN(stby_reg_en), .LXT_EN(lxt_en), .LOW_SPEED_RC_OSC_EN(low_speed_rc_osc_en),
      .TMR_CLK_EN(tmr_clk_en), .WDT_CLK_EN(wdt_clk_en),
      .UART_CLK_EN(uart_clk_en), .WAKE_REQ(wake_req));
   pm_link_monitor u_mon (.clk(clk), .rst_n(rst_n),
      .wfi(u_pm_link_if.wfi),
      .deep_sleep_select(u_pm_link_if.deep_sleep_select),
      .irq_pending(u_pm_link_if.irq_pending),
      .reg_wr(u_pm_link_if.reg_wr), .reg_rd(u_pm_link_if.reg_rd),
      .reg_sel(u_pm_link_if.reg_sel), .reg_wdata(u_pm_link_if.reg_wdata),
      .reg_rdata(u_pm_link_if.reg_rdata), .reg_ack(u_pm_link_if.reg_ack),
      .pm_mode(u_pm_link_if.pm_mode));

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic finish_test();
      $display("checks %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // Answer taken at the rising edge that sees pready, released there
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         err_count++;
         finish_test();
      end
   endtask

   // Busy must drop before another link access is launched
   task automatic idle_wait();
      int n;
      n = 0;
      do begin
         apb(1'b0, APB_STATUS, '0);
         n++;
      end while (r[STS_BUSY_BIT] !== 1'b0 && n < 20);
      if (n >= 20) begin
         err_count++;
         finish_test();
      end
   endtask

   task automatic lwr(input logic [3:0] s, input logic [31:0] d);
      apb(1'b1, APB_ADDR, {28'h0, s});
      apb(1'b1, APB_WDATA, d);
      idle_wait();
   endtask

   task automatic lrd(input logic [3:0] s, input logic [31:0] exp);
      apb(1'b1, APB_ADDR, {28'h0, s});
      apb(1'b1, APB_RDATA, '0);
      idle_wait();
      apb(1'b0, APB_RDATA, '0);
      chk(r, exp);
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_reset();
      chk({cpu_clk_en, main_reg_en, stby_reg_en}, 32'h7);
      chk(gate_en, 32'hfff);
      apb(1'b0, APB_STATUS, '0);
      chk(r[1:0], 32'h0);
      apb(1'b0, 8'h14, '0);
      chk(e, 32'h1);
      chk(r, 32'h0);
      $display("reset test done");
   endtask

   task automatic t_idle();
      apb(1'b1, APB_CMD, 32'h1);
      cyc(3);
      chk({cpu_clk_en, main_reg_en, gate_en}, {2'h1, 12'h7ff});
      @(posedge clk) irq <= 1'b1;
      cyc(4);
      chk(cpu_clk_en, 32'h1);
      @(posedge clk) irq <= 1'b0;
      $display("idle test done");
   endtask

   task automatic t_pdown();
      lwr(REG_PWR_CTL, 32'h82);
      lwr(REG_CLK_SEL, 32'h19);
      apb(1'b1, APB_CMD, 32'h3);
      cyc(3);
      chk({cpu_clk_en, main_reg_en, stby_reg_en, gate_en},
         {3'h1, 12'h0});
      chk({lxt_en, low_speed_rc_osc_en}, 32'h2);
      chk({tmr_clk_en, wdt_clk_en, uart_clk_en}, 32'h5);
      @(posedge clk) evt[0] <= 1'b1;
      @(posedge clk) evt[0] <= 1'b0;
      cyc(3);
      chk(cpu_clk_en, 32'h0);
      @(posedge clk) evt[4] <= 1'b1;
      @(posedge clk) evt[4] <= 1'b0;
      cyc(3);
      chk({cpu_clk_en, wake_req}, 32'h3);
      chk({main_reg_en, gate_en}, 32'h1fff);
      apb(1'b1, APB_CMD, 32'h0);
      lrd(REG_BOD_CTL, MASK_BOD);
      lwr(REG_BOD_CTL, MASK_BOD);
      lrd(REG_BOD_CTL, 32'h0);
      chk(wake_req, 32'h0);
      $display("power-down test done");
   endtask

   // Descending clear hits each acknowledge-done bit while still set
   task automatic t_flags();
      logic [31:0] left;
      @(posedge clk) evt <= '1;
      @(posedge clk) evt <= '0;
      for (int i = FLAG_LAST; i >= FLAG_FIRST; i--) begin
         left = (i == 8 || i == 10) ? 32'h1 : 32'h0;
         lrd(4'(i), mt[i-FLAG_FIRST]);
         lwr(4'(i), mt[i-FLAG_FIRST]);
         lrd(4'(i), left);
      end
      chk(wake_req, 32'h1);
      lwr(REG_I2C_WK, 32'h1);
      lwr(REG_UNIVERSAL_SERIAL_UNIT_WK, 32'h1);
      lrd(REG_I2C_WK, 32'h0);
      lrd(REG_UNIVERSAL_SERIAL_UNIT_WK, 32'h0);
      lrd(4'hf, 32'h0);
      chk(wake_req, 32'h0);
      $display("flag test done");
   endtask

   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_idle();
      t_pdown();
      t_flags();
      finish_test();
   end
endmodule
